// [common/ermc_map.vh]
// Contract
// RL1: Run bit starts reception and data requests
// RL2: Run bit clear sends machines to idle
// RL3: Pad bit strips pad bytes from frames
// RL4: Promiscuous bit accepts any destination address
// RL5: Check-off bit skips CRC, framing, length checks
// RL6: Keep-FCS bit keeps last four bytes, else stripped
// RL7: Drop-own bit discards frames from own address
// RL8: Group bit accepts all group-addressed frames
// RL9: Hash bit filters multicast through hash table
// RL10: Filter bit uses address filter registers
// RL11: Software quiesces run bit before parameter writes
// RL12: Software quiesces hash bit before table writes
// RL13: Software quiesces filter bit before filter writes
// RL14: Over-maximum byte count marks frame invalid
// RL15: Under-minimum byte count marks frame invalid
// RL16: High station word matches destination bits 47:32
// RL17: Middle station word matches destination bits 31:16
// RL18: Low station word matches destination bits 15:0
// RL19: Configuration bits 4 to 1 read zero
`ifndef ERMC_MAP_VH
`define ERMC_MAP_VH
// Register byte addresses
`define ERMC_ADDR_CFG 28'h8c0630c
`define ERMC_ADDR_MAX 28'h8c06310
`define ERMC_ADDR_MIN 28'h8c06314
`define ERMC_ADDR_SAH 28'h8c06318
`define ERMC_ADDR_SAM 28'h8c0631c
// Configuration field positions
`define ERMC_CFG_RUN 0
`define ERMC_CFG_PAD 5
`define ERMC_CFG_PROM 6
`define ERMC_CFG_NOCHK 7
`define ERMC_CFG_KEEPFCS 8
`define ERMC_CFG_OWN 9
`define ERMC_CFG_GROUP 10
`define ERMC_CFG_HASH 11
`define ERMC_CFG_AFILT 12
// Writable configuration bits
`define ERMC_CFG_WMASK 13'h1fe1
// Reset values
`define ERMC_RST_CFG 13'h0000
`define ERMC_RST_MAX 13'h05ee
`define ERMC_RST_MIN 8'h40
`define ERMC_RST_SA 16'h0000
// Frame constants
`define ERMC_NIB_PRE 4'h5
`define ERMC_NIB_SFD 4'hd
`define ERMC_CRC_POLY 32'hedb88320
`define ERMC_CRC_GOOD 32'hdebb20e3
`define ERMC_PAD_LIMIT 16'h002e
`define ERMC_HDR_LEN 13'h000e
`define ERMC_FCS_LEN 3'h4
`endif

// [logic/ermc_receive_mac.v]
`timescale 1ns/1ps
`include "ermc_map.vh"
module ermc_receive_mac (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // PIO register port
  input wire i_pio_wr,
  input wire i_pio_rd,
  input wire [27:0] i_pio_addr,
  input wire [31:0] i_pio_wdata,
  output reg [31:0] o_pio_rdata,
  output reg o_pio_ack,
  // Neighbour state: low address word, hash table, filter hit
  input wire [15:0] i_station_address_low,
  input wire [63:0] i_hash_table,
  input wire i_addr_filter_hit,
  // MII receive pins
  input wire i_mii_rx_clk,
  input wire i_mii_rx_dv,
  input wire i_mii_rx_er,
  input wire [3:0] i_mii_rxd,
  // Byte stream to the receive DMA engine
  output reg o_dma_valid,
  output reg [7:0] o_dma_data,
  output reg o_frame_end,
  output reg o_frame_bad
);

  // Machine states
  localparam ST_IDLE = 3'd0;
  localparam ST_LISTEN = 3'd1;
  localparam ST_PRE = 3'd2;
  localparam ST_DATA = 3'd3;
  localparam ST_FLUSH = 3'd4;
  localparam ST_SKIP = 3'd5;

  // One byte of the reflected Ethernet CRC
  function [31:0] crc_byte;
    input [31:0] c;
    input [7:0] d;
    integer k;
    reg [31:0] r;
    begin
      r = c;
      for (k = 0; k < 8; k = k + 1) begin
        if (r[0] ^ d[k])
          r = (r >> 1) ^ `ERMC_CRC_POLY;
        else
          r = r >> 1;
      end
      crc_byte = r;
    end
  endfunction

  // Software registers
  reg [12:0] cfg_q; // Configuration as written
  reg [12:0] max_q; // Longest legal frame
  reg [7:0] min_q; // Shortest legal frame
  reg [15:0] sah_q; // Station address bits 47:32
  reg [15:0] sam_q; // Station address bits 31:16
  reg [12:0] fcfg_q; // Configuration frozen per frame

  // Pin synchroniser, three stages
  reg [6:0] s1_q;
  reg [6:0] s2_q;
  reg [6:0] s3_q;
  reg [6:0] filt_q; // Settled pin levels
  reg clk_prev_q; // Last settled receive clock
  wire [6:0] filt_d;
  wire rx_edge;
  wire rx_dv;
  wire rx_er;
  wire [3:0] rx_nib;

  // Receive datapath state
  reg [2:0] st_q;
  reg phase_q; // High nibble expected next
  reg [3:0] nib_q; // Low nibble of current byte
  reg [3:0] prev_q; // Previous preamble nibble
  reg [12:0] cnt_q; // Bytes seen this frame
  reg [31:0] crc_q;
  reg [47:0] da_q; // Destination address
  reg [47:0] sa_q; // Source address
  reg [7:0] lhi_q; // Length field high byte
  reg padv_q; // Length field implies padding
  reg [12:0] lim_q; // Bytes before pad begins
  reg [5:0] hidx_q; // Hash index from address CRC
  reg [31:0] dl_q; // Four-byte hold for FCS strip
  reg [2:0] hc_q; // Bytes in the hold
  reg long_q; // Passed maximum length
  reg er_q; // Code violation seen
  reg bad_q; // Verdict kept across flush
  reg [2:0] fl_q; // Bytes left to flush

  // Decoded events and verdict terms
  wire byte_ev;
  wire [7:0] byte_v;
  wire [12:0] emit_idx;
  wire emit_pad;
  wire frame_busy;
  wire da_me;
  wire sa_me;
  wire accept;
  wire errs;
  wire verdict;
  wire [31:0] crc_nx = crc_byte(crc_q, byte_v); // CRC with this byte in
  reg [31:0] rd_d;

  // Settle each pin once stages two and three agree
  assign filt_d = (s2_q & s3_q) | ((s2_q ^ s3_q) & filt_q);
  assign rx_edge = filt_q[6] & ~clk_prev_q;
  assign rx_er = filt_q[5];
  assign rx_dv = filt_q[4];
  assign rx_nib = filt_q[3:0];

  // Synchroniser chain and receive clock edge
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= 7'h00;
      s2_q <= 7'h00;
      s3_q <= 7'h00;
      filt_q <= 7'h00;
      clk_prev_q <= 1'b0;
    end else begin
      s1_q <= {i_mii_rx_clk, i_mii_rx_er, i_mii_rx_dv, i_mii_rxd};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
      clk_prev_q <= filt_q[6];
    end
  end

  // A byte completes on the high nibble
  assign byte_ev = rx_edge & rx_dv & phase_q & (st_q == ST_DATA);
  assign byte_v = {rx_nib, nib_q};
  assign emit_idx = cnt_q - {10'h000, `ERMC_FCS_LEN}; // Oldest held byte
  assign emit_pad = fcfg_q[`ERMC_CFG_PAD] & padv_q &
                    (emit_idx >= lim_q); // [RL3]
  assign frame_busy = (st_q != ST_IDLE) & (st_q != ST_LISTEN);

  // Station match over all three words
  assign da_me = (da_q[47:32] == sah_q) & // [RL16]
                 (da_q[31:16] == sam_q) & // [RL17]
                 (da_q[15:0] == i_station_address_low); // [RL18]
  assign sa_me = (sa_q[47:32] == sah_q) & (sa_q[31:16] == sam_q) &
                 (sa_q[15:0] == i_station_address_low);
  // Bit 40 is the group bit, first on the wire
  assign accept = fcfg_q[`ERMC_CFG_PROM] | // [RL4]
                  (fcfg_q[`ERMC_CFG_GROUP] & da_q[40]) | // [RL8]
                  (fcfg_q[`ERMC_CFG_HASH] & da_q[40] &
                   i_hash_table[hidx_q]) | // [RL9]
                  (fcfg_q[`ERMC_CFG_AFILT] & i_addr_filter_hit) | // [RL10]
                  (&da_q) | da_me;
  // Odd nibble count is a framing fault
  assign errs = (crc_q != `ERMC_CRC_GOOD) | long_q | er_q | phase_q |
                (cnt_q < {5'h00, min_q}); // [RL15]
  assign verdict = ~accept |
                   (fcfg_q[`ERMC_CFG_OWN] & sa_me) | // [RL7]
                   (~fcfg_q[`ERMC_CFG_NOCHK] & errs); // [RL5]

  // Receive protocol machine
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= ST_IDLE;
      phase_q <= 1'b0;
      nib_q <= 4'h0;
      prev_q <= 4'h0;
      cnt_q <= 13'h0000;
      crc_q <= 32'h00000000;
      da_q <= 48'h000000000000;
      sa_q <= 48'h000000000000;
      lhi_q <= 8'h00;
      padv_q <= 1'b0;
      lim_q <= 13'h0000;
      hidx_q <= 6'h00;
      dl_q <= 32'h00000000;
      hc_q <= 3'h0;
      long_q <= 1'b0;
      er_q <= 1'b0;
      bad_q <= 1'b0;
      fl_q <= 3'h0;
      fcfg_q <= `ERMC_RST_CFG;
      o_dma_valid <= 1'b0;
      o_dma_data <= 8'h00;
      o_frame_end <= 1'b0;
      o_frame_bad <= 1'b0;
    end else begin
      o_dma_valid <= 1'b0;
      o_frame_end <= 1'b0;
      o_frame_bad <= 1'b0;
      case (st_q)
        ST_IDLE: begin // Only start between frames
          if (cfg_q[`ERMC_CFG_RUN] & ~rx_dv) // [RL1]
            st_q <= ST_LISTEN;
        end
        ST_LISTEN: begin
          if (!cfg_q[`ERMC_CFG_RUN]) begin
            st_q <= ST_IDLE; // [RL2]
          end else if (rx_dv) begin // Freeze controls for this frame
            fcfg_q <= cfg_q;
            prev_q <= 4'h0;
            st_q <= ST_PRE;
          end
        end
        ST_PRE: begin
          if (!cfg_q[`ERMC_CFG_RUN]) begin
            st_q <= ST_SKIP; // [RL2]
          end else if (!rx_dv) begin
            st_q <= ST_LISTEN; // Carrier lost, no clock edge needed
          end else if (rx_edge && rx_nib == `ERMC_NIB_SFD &&
                       prev_q == `ERMC_NIB_PRE) begin // Delimiter found
            st_q <= ST_DATA;
            phase_q <= 1'b0;
            cnt_q <= 13'h0000;
            crc_q <= 32'hffffffff;
            padv_q <= 1'b0;
            hc_q <= 3'h0;
            long_q <= 1'b0;
            er_q <= 1'b0;
          end else if (rx_edge) begin
            prev_q <= rx_nib;
          end
        end
        ST_DATA: begin
          if (rx_edge & rx_dv) begin
            phase_q <= ~phase_q;
            nib_q <= rx_nib;
            if (rx_er)
              er_q <= 1'b1;
          end
          if (byte_ev) begin
            if (cnt_q != 13'h1fff) // Saturate rather than wrap
              cnt_q <= cnt_q + 13'h0001;
            if (cnt_q >= max_q)
              long_q <= 1'b1; // [RL14]
            crc_q <= crc_nx;
            if (cnt_q < 13'h0006)
              da_q <= {da_q[39:0], byte_v};
            else if (cnt_q < 13'h000c)
              sa_q <= {sa_q[39:0], byte_v};
            if (cnt_q == 13'h0005)
              hidx_q <= crc_nx[31:26];
            if (cnt_q == 13'h000c)
              lhi_q <= byte_v;
            if (cnt_q == 13'h000d) begin
              padv_q <= {lhi_q, byte_v} < `ERMC_PAD_LIMIT;
              lim_q <= `ERMC_HDR_LEN + {5'h00, byte_v};
            end
            // Hold the last four bytes until the end is known
            dl_q <= {dl_q[23:0], byte_v}; // [RL6]
            if (hc_q != `ERMC_FCS_LEN)
              hc_q <= hc_q + 3'h1;
            if (hc_q == `ERMC_FCS_LEN && !emit_pad) begin
              o_dma_valid <= 1'b1; // [RL1]
              o_dma_data <= dl_q[31:24];
            end
          end else if (!rx_dv) begin // No clock edge needed to end
            bad_q <= verdict;
            if (fcfg_q[`ERMC_CFG_KEEPFCS] &&
                hc_q == `ERMC_FCS_LEN) begin
              fl_q <= `ERMC_FCS_LEN; // [RL6]
              st_q <= ST_FLUSH; // Kept FCS drains after the frame
            end else begin
              o_frame_end <= 1'b1;
              o_frame_bad <= verdict;
              st_q <= cfg_q[`ERMC_CFG_RUN] ? ST_LISTEN : ST_IDLE;
            end
          end
        end
        ST_FLUSH: begin
          o_dma_valid <= 1'b1;
          o_dma_data <= dl_q[31:24];
          dl_q <= {dl_q[23:0], 8'h00};
          fl_q <= fl_q - 3'h1;
          if (fl_q == 3'h1) begin
            o_frame_end <= 1'b1;
            o_frame_bad <= bad_q;
            st_q <= cfg_q[`ERMC_CFG_RUN] ? ST_LISTEN : ST_IDLE; // [RL2]
          end
        end
        ST_SKIP: begin
          // Let a stray frame pass before idling
          if (!rx_dv)
            st_q <= ST_IDLE; // [RL2]
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
  // Read mux; busy machine keeps quiesce bits reading one
  always @* begin
    rd_d = 32'h00000000;
    case (i_pio_addr)
      `ERMC_ADDR_CFG: begin
        rd_d[12:0] = cfg_q & `ERMC_CFG_WMASK; // [RL19]
        rd_d[`ERMC_CFG_RUN] = cfg_q[`ERMC_CFG_RUN] | frame_busy;
        rd_d[`ERMC_CFG_HASH] = cfg_q[`ERMC_CFG_HASH] |
                               (frame_busy & fcfg_q[`ERMC_CFG_HASH]);
        rd_d[`ERMC_CFG_AFILT] = cfg_q[`ERMC_CFG_AFILT] |
                                (frame_busy & fcfg_q[`ERMC_CFG_AFILT]);
      end
      `ERMC_ADDR_MAX: rd_d[12:0] = max_q;
      `ERMC_ADDR_MIN: rd_d[7:0] = min_q;
      `ERMC_ADDR_SAH: rd_d[15:0] = sah_q;
      `ERMC_ADDR_SAM: rd_d[15:0] = sam_q;
      default: rd_d = 32'h00000000;
    endcase
  end

  // Register writes and one-cycle acknowledge
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_q <= `ERMC_RST_CFG;
      max_q <= `ERMC_RST_MAX;
      min_q <= `ERMC_RST_MIN;
      sah_q <= `ERMC_RST_SA;
      sam_q <= `ERMC_RST_SA;
      o_pio_rdata <= 32'h00000000;
      o_pio_ack <= 1'b0;
    end else begin
      o_pio_ack <= i_pio_wr | i_pio_rd;
      o_pio_rdata <= i_pio_rd ? rd_d : 32'h00000000;
      // No write interlock: software quiesces first
      if (i_pio_wr) begin
        case (i_pio_addr)
          `ERMC_ADDR_CFG:
            cfg_q <= i_pio_wdata[12:0] & `ERMC_CFG_WMASK; // [RL19]
          `ERMC_ADDR_MAX: max_q <= i_pio_wdata[12:0];
          `ERMC_ADDR_MIN: min_q <= i_pio_wdata[7:0];
          `ERMC_ADDR_SAH: sah_q <= i_pio_wdata[15:0];
          `ERMC_ADDR_SAM: sam_q <= i_pio_wdata[15:0];
          default: cfg_q <= cfg_q;
        endcase
      end
    end
  end
endmodule

// [dv/ermc_receive_mac_monitor.sv]
`timescale 1ns/1ps
`include "ermc_map.vh"
module ermc_receive_mac_monitor (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // Register port
  input wire i_pio_wr,
  input wire i_pio_rd,
  input wire [27:0] i_pio_addr,
  input wire [31:0] i_pio_wdata,
  input wire [31:0] o_pio_rdata,
  input wire o_pio_ack,
  // Stream to the receive DMA engine
  input wire o_dma_valid,
  input wire o_frame_end
);
  // Last written run bit, and how long it has stayed clear
  reg run_q;
  reg [11:0] off_q;
  wire rd_only = i_pio_rd && !i_pio_wr;
  wire mapped = (i_pio_addr == `ERMC_ADDR_CFG) ||
    (i_pio_addr == `ERMC_ADDR_MAX) || (i_pio_addr == `ERMC_ADDR_MIN) ||
    (i_pio_addr == `ERMC_ADDR_SAH) || (i_pio_addr == `ERMC_ADDR_SAM);
  // Saturating, so a long stop cannot wrap back under the limit
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_q <= 1'b0;
      off_q <= 12'h000;
    end else begin
      if (i_pio_wr && i_pio_addr == `ERMC_ADDR_CFG)
        run_q <= i_pio_wdata[0];
      if (run_q)
        off_q <= 12'h000;
      else if (off_q != 12'hfff)
        off_q <= off_q + 12'h001;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_req;
    i_pio_wr || i_pio_rd;
  endsequence
  // Maximum length written, then read alone on the next edge
  property p_max_back;
    logic [12:0] v;
    (i_pio_wr && i_pio_addr == `ERMC_ADDR_MAX, v = i_pio_wdata[12:0])
      ##1 (rd_only && i_pio_addr == `ERMC_ADDR_MAX)
      |=> o_pio_rdata == {19'h0, v};
  endproperty
  chk_ack_follows:
    assert property (s_req |=> o_pio_ack) else $error("ack missing");
  chk_ack_cause:
    assert property (o_pio_ack |-> $past(i_pio_wr || i_pio_rd))
    else $error("ack without request");
  chk_rdata_idle:
    assert property (!o_pio_ack |-> o_pio_rdata == 32'h0)
    else $error("read data outside ack");
  chk_resv_zero:
    assert property (rd_only && i_pio_addr == `ERMC_ADDR_CFG |=>
      o_pio_rdata[4:1] == 4'h0 && o_pio_rdata[31:13] == 19'h0)
    else $error("reserved config bits set");
  chk_max_back:
    assert property (p_max_back) else $error("max length readback");
  chk_unmapped_zero:
    assert property (i_pio_rd && !mapped |=> o_pio_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_end_pulse:
    assert property (o_frame_end |=> !o_frame_end)
    else $error("frame end longer than one cycle");
  chk_quiet_off:
    assert property (off_q > 12'd3000 |-> !o_dma_valid && !o_frame_end)
    else $error("output while stopped");
endmodule
bind ermc_receive_mac ermc_receive_mac_monitor ermc_receive_mac_monitor_inst (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_pio_wr(i_pio_wr),
  .i_pio_rd(i_pio_rd), .i_pio_addr(i_pio_addr), .i_pio_wdata(i_pio_wdata),
  .o_pio_rdata(o_pio_rdata), .o_pio_ack(o_pio_ack),
  .o_dma_valid(o_dma_valid), .o_frame_end(o_frame_end)
);

// [dv/ermc_mii_phy.sv]
`timescale 1ns/1ps
module ermc_mii_phy (
  // MII receive pins
  output logic o_rx_clk,
  output logic o_rx_dv,
  output logic o_rx_er,
  output logic [3:0] o_rxd
);
  // Frame bytes, loaded by the bench
  logic [7:0] frm [0:127];
  initial begin
    o_rx_clk = 1'b0;
    o_rx_dv = 1'b0;
    o_rx_er = 1'b0;
    o_rxd = 4'h0;
  end
  // One nibble at 25 MHz, data settles while the clock is low
  task nib(input logic [3:0] v);
    o_rxd = v;
    o_rx_dv = 1'b1;
    #20;
    o_rx_clk = 1'b1;
    #20;
    o_rx_clk = 1'b0;
  endtask
  // Preamble, start nibble, then bytes low nibble first
  task send(input int n);
    int i;
    for (i = 0; i < 15; i++)
      nib(4'h5);
    nib(4'hd);
    for (i = 0; i < n; i++) begin
      nib(frm[i][3:0]);
      nib(frm[i][7:4]);
    end
    // Released: clock stands, data no longer holds the last nibble
    #20;
    o_rx_dv = 1'b0;
    o_rxd = ~o_rxd;
  endtask
endmodule

// [dv/test_ermc_receive_mac.sv]
`timescale 1ns/1ps
`include "ermc_map.vh"
module test_ermc_receive_mac;
  typedef struct {
    logic [12:0] cfg; logic [12:0] mx; logic [7:0] mn; logic [47:0] da;
    int len; logic [4:0] fl; int n; logic bad;
  } ermc_row_t;
  // Station is 12:34:56:78:9a:bc; variants miss one word or are group
  localparam logic [47:0] da_own = 48'h123456789abc;
  localparam logic [47:0] da_hiw = 48'h163456789abc;
  localparam logic [47:0] da_mid = 48'h123457789abc;
  localparam logic [47:0] da_low = 48'h123456789abd;
  localparam logic [47:0] da_grp = 48'h133456789abc;
  // Flags: own source, bad CRC, short length field, hash hit, filter hit
  ermc_row_t rows [0:18] = '{
    '{13'h0001, 13'h05ee, 8'h40, da_own, 64, 5'h00, 60, 1'b0},
    '{13'h0101, 13'h05ee, 8'h40, da_own, 64, 5'h00, 64, 1'b0},
    '{13'h0001, 13'h05ee, 8'h40, da_hiw, 64, 5'h00, 60, 1'b1},
    '{13'h0001, 13'h05ee, 8'h40, da_mid, 64, 5'h00, 60, 1'b1},
    '{13'h0001, 13'h05ee, 8'h40, da_low, 64, 5'h00, 60, 1'b1},
    '{13'h0041, 13'h05ee, 8'h40, da_hiw, 64, 5'h00, 60, 1'b0},
    '{13'h0401, 13'h05ee, 8'h40, da_grp, 64, 5'h00, 60, 1'b0},
    '{13'h0001, 13'h05ee, 8'h40, da_grp, 64, 5'h00, 60, 1'b1},
    '{13'h0801, 13'h05ee, 8'h40, da_grp, 64, 5'h08, 60, 1'b0},
    '{13'h0801, 13'h05ee, 8'h40, da_grp, 64, 5'h00, 60, 1'b1},
    '{13'h1001, 13'h05ee, 8'h40, da_hiw, 64, 5'h10, 60, 1'b0},
    '{13'h1001, 13'h05ee, 8'h40, da_hiw, 64, 5'h00, 60, 1'b1},
    '{13'h0201, 13'h05ee, 8'h40, da_own, 64, 5'h01, 60, 1'b1},
    '{13'h0001, 13'h05ee, 8'h40, da_own, 64, 5'h02, 60, 1'b1},
    '{13'h0081, 13'h05ee, 8'h40, da_own, 64, 5'h02, 60, 1'b0},
    '{13'h0001, 13'h0040, 8'h40, da_own, 65, 5'h00, 61, 1'b1},
    '{13'h0001, 13'h0040, 8'h40, da_own, 64, 5'h00, 60, 1'b0},
    '{13'h0001, 13'h05ee, 8'h41, da_own, 64, 5'h00, 60, 1'b1},
    '{13'h0021, 13'h05ee, 8'h40, da_own, 64, 5'h04, 16, 1'b0}};
  logic i_mclk, i_rst_n, i_pio_wr, i_pio_rd, i_addr_filter_hit, last_bad;
  logic [27:0] i_pio_addr;
  logic [31:0] i_pio_wdata, r;
  logic [63:0] i_hash_table;
  wire [31:0] o_pio_rdata;
  wire [7:0] o_dma_data;
  wire [3:0] mii_d;
  wire o_pio_ack, o_dma_valid, o_frame_end, o_frame_bad;
  wire mii_clk, mii_dv, mii_er;
  int failures, samples_checked, cyc, got, ends, k;
  always #2 i_mclk = ~i_mclk;
  ermc_receive_mac ermc_receive_mac_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_pio_wr(i_pio_wr), .i_pio_rd(i_pio_rd), .i_pio_addr(i_pio_addr),
    .i_pio_wdata(i_pio_wdata), .o_pio_rdata(o_pio_rdata),
    .o_pio_ack(o_pio_ack), .i_station_address_low(16'h9abc),
    .i_hash_table(i_hash_table), .i_addr_filter_hit(i_addr_filter_hit),
    .i_mii_rx_clk(mii_clk), .i_mii_rx_dv(mii_dv), .i_mii_rx_er(mii_er),
    .i_mii_rxd(mii_d), .o_dma_valid(o_dma_valid), .o_dma_data(o_dma_data),
    .o_frame_end(o_frame_end), .o_frame_bad(o_frame_bad));
  ermc_mii_phy ermc_mii_phy_inst (.o_rx_clk(mii_clk), .o_rx_dv(mii_dv),
    .o_rx_er(mii_er), .o_rxd(mii_d));
  task finish_test;
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task check(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  // One access, entered just after an edge; answer sampled one edge later
  task access(input logic w, input logic [27:0] a, input logic [31:0] d);
    i_pio_wr <= w;
    i_pio_rd <= !w;
    i_pio_addr <= a;
    i_pio_wdata <= d;
    @(posedge i_mclk);
    i_pio_wr <= 1'b0;
    i_pio_rd <= 1'b0;
    @(posedge i_mclk);
    r = o_pio_rdata;
    check(o_pio_ack === 1'b1, "no ack");
  endtask
  // Stop the receiver and wait until it reads back stopped
  task quiesce;
    access(1'b1, `ERMC_ADDR_CFG, 32'h0);
    k = 0;
    do begin
      access(1'b0, `ERMC_ADDR_CFG, 32'h0);
      k++;
    end while (r[0] !== 1'b0 && k < 100);
    check(r[0] === 1'b0, "receiver never stopped");
  endtask
  // Build a frame with its FCS, send it, wait for the verdict
  task send_frame(input logic [47:0] da, input logic [4:0] fl, input int n);
    logic [31:0] c;
    logic [7:0] b;
    int i, j;
    c = 32'hffffffff;
    for (i = 0; i < n - 4; i++) begin
      b = i[7:0];
      if (i < 6)
        b = da[47 - 8 * i -: 8];
      else if (i < 12 && fl[0])
        b = da_own[95 - 8 * i -: 8];
      else if (i == 12)
        b = fl[2] ? 8'h00 : 8'h08;
      else if (i == 13)
        b = fl[2] ? 8'h02 : 8'h00;
      ermc_mii_phy_inst.frm[i] = b;
      for (j = 0; j < 8; j++)
        c = (c >> 1) ^ (((c[0] ^ b[j]) == 1'b1) ? 32'hedb88320 : 32'h0);
    end
    c = ~c ^ {31'h0, fl[1]};
    for (i = 0; i < 4; i++)
      ermc_mii_phy_inst.frm[n - 4 + i] = c[8 * i +: 8];
    got = 0;
    ends = 0;
    ermc_mii_phy_inst.send(n);
    k = 0;
    while (ends == 0 && k < 3000) begin
      @(negedge i_mclk);
      k++;
    end
    @(posedge i_mclk);
  endtask
  // Stream monitor and run limit
  always @(posedge i_mclk) begin
    cyc++;
    if (o_dma_valid) begin
      check(o_dma_data === ermc_mii_phy_inst.frm[got], "byte");
      got++;
    end
    if (o_frame_end) begin
      ends++;
      last_bad = o_frame_bad;
    end
    if (cyc == 90000) begin
      failures++;
      finish_test;
    end
  end
  initial begin
    i_mclk = 1'b0;
    i_rst_n = 1'b0;
    {i_pio_wr, i_pio_rd, i_addr_filter_hit} = 3'h0;
    i_pio_addr = 28'h0;
    i_pio_wdata = 32'h0;
    i_hash_table = 64'h0;
    repeat (6) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    access(1'b1, `ERMC_ADDR_SAH, 32'h1234);
    access(1'b1, `ERMC_ADDR_SAM, 32'h5678);
    foreach (rows[q]) begin
      quiesce;
      access(1'b1, `ERMC_ADDR_MAX, {19'h0, rows[q].mx});
      access(1'b1, `ERMC_ADDR_MIN, {24'h0, rows[q].mn});
      i_hash_table <= {64{rows[q].fl[3]}};
      i_addr_filter_hit <= rows[q].fl[4];
      access(1'b1, `ERMC_ADDR_CFG, {19'h0, rows[q].cfg});
      send_frame(rows[q].da, rows[q].fl, rows[q].len);
      check(got == rows[q].n, "byte count");
      check(last_bad === rows[q].bad, "verdict");
    end
    // Stopped receiver ignores a whole frame
    quiesce;
    send_frame(da_own, 5'h00, 64);
    check(got == 0 && ends == 0, "output while stopped");
    // Write then read on consecutive edges
    i_pio_wr <= 1'b1;
    i_pio_addr <= `ERMC_ADDR_MAX;
    i_pio_wdata <= 32'h00000abc;
    @(posedge i_mclk);
    i_pio_wr <= 1'b0;
    i_pio_rd <= 1'b1;
    @(posedge i_mclk);
    i_pio_rd <= 1'b0;
    @(posedge i_mclk);
    check(o_pio_rdata === 32'h00000abc, "max readback");
    // Second reset, defaults, reserved bits, unmapped place
    i_rst_n <= 1'b0;
    repeat (6) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    access(1'b0, `ERMC_ADDR_MAX, 32'h0);
    check(r === 32'h000005ee, "max default");
    access(1'b0, `ERMC_ADDR_MIN, 32'h0);
    check(r === 32'h00000040, "min default");
    access(1'b0, `ERMC_ADDR_SAH, 32'h0);
    check(r === 32'h0, "high word default");
    access(1'b0, `ERMC_ADDR_SAM, 32'h0);
    check(r === 32'h0, "middle word default");
    access(1'b1, `ERMC_ADDR_CFG, 32'h0000001e);
    access(1'b0, `ERMC_ADDR_CFG, 32'h0);
    check(r === 32'h0, "reserved bits");
    access(1'b1, 28'h8c06300, 32'hffff);
    access(1'b0, 28'h8c06300, 32'h0);
    check(r === 32'h0, "unmapped read");
    finish_test;
  end
endmodule
